/* rtl/psk_fanout.sv */
// How it works
// - bang-bang detector compares reference and loop return, steering oscillator rate
// - band select clamps oscillator rate to 15-30, 25-50 or 40-100 MHz
// - time unit is one oscillator cycle over N: 44, 26 or 16 by band
// - four pairs, both outputs of a pair identical, each with two select digits
// - pairs 1 and 2 give -4 to +4 units, MID/MID zero
// - pairs 3 and 4 give -6 to +6 units in steps of two
// - pair 1 undivided; LOW/LOW halves 3,4; HIGH/HIGH quarters 3, inverts 4
// - offsets hold relative to reference when the returned output has zero offset
// - three-level pins: supply HIGH, ground LOW, open MID
// - divided output returned means reference runs at half or quarter rate
// - bypass LOW gives normal locked operation with all functions
// - bypass MID or HIGH drives all outputs straight from the reference
// - in bypass each pair follows only its selects and the reference
// - a pair or band select change drops validity until the loop locks again; in bypass, for one cycle
`include "psk_map.svh"

module psk_fanout #(
  parameter int unsigned LOCK_HITS = `PSK_LOCK_HITS,
  parameter int unsigned LOCK_WIN = `PSK_LOCK_WIN,
  parameter int unsigned FREQ_STEP = `PSK_FREQ_STEP
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ref_clock_input,
  input wire logic loop_return_input,
  input wire psk_pkg::psk_pin_t band_select,
  input wire psk_pkg::psk_pin_t bypass_select,
  input wire psk_pkg::psk_pin_t [3:0] pair_select_low_digit,
  input wire psk_pkg::psk_pin_t [3:0] pair_select_high_digit,
  output logic [3:0] pair_output_a,
  output logic [3:0] pair_output_b,
  output logic outputs_valid
);

  localparam int SW = 22;
  localparam int PW = `PSK_PHASE_W;
  localparam psk_pkg::psk_word_t STEP_W = psk_pkg::psk_word_t'(FREQ_STEP);
  localparam psk_pkg::psk_word_t FREQ_RST = psk_pkg::psk_word_t'(
    (psk_pkg::band_min(psk_pkg::PSK_LVL_MID) + psk_pkg::band_max(psk_pkg::PSK_LVL_MID)) / 2);
  localparam psk_pkg::psk_word_t NUDGE_W = psk_pkg::psk_word_t'(`PSK_PHASE_NUDGE);
  // reset as if bypass were strapped low, so nothing reads valid before the pins arrive
  localparam logic [SW-1:0] RAW_RST = 22'h010000;

  // ****************************************
  // input conditioning
  // ****************************************
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic ref_prev_reg, ret_prev_reg;

  assign raw = {ref_clock_input, loop_return_input, band_select, bypass_select,
                pair_select_low_digit, pair_select_high_digit};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= RAW_RST;
      s2_reg <= RAW_RST;
      s3_reg <= RAW_RST;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit moves only once the last two stages agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      filt_reg <= RAW_RST;
    end else begin
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_prev_reg <= 1'b0;
      ret_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= filt_reg[21];
      ret_prev_reg <= filt_reg[20];
    end
  end

  logic ref_f, ref_rise, ret_rise, bypass_on;
  psk_pkg::psk_level_t band_lvl;
  psk_pkg::psk_pin_t [3:0] lo_f, hi_f;
  logic [15:0] sel_prev_reg;
  logic sel_change;

  assign ref_f = filt_reg[21];
  assign ref_rise = filt_reg[21] & ~ref_prev_reg;
  assign ret_rise = filt_reg[20] & ~ret_prev_reg;
  assign band_lvl = psk_pkg::decode_level(filt_reg[19:18]);
  assign bypass_on = psk_pkg::decode_level(filt_reg[17:16]) != psk_pkg::PSK_LVL_LOW;
  assign lo_f = filt_reg[15:8];
  assign hi_f = filt_reg[7:0];
  assign sel_change = sel_prev_reg != filt_reg[15:0];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_prev_reg <= '0;
    end else begin
      sel_prev_reg <= filt_reg[15:0];
    end
  end

  // ****************************************
  // band and tuned oscillator
  // ****************************************
  psk_pkg::psk_level_t band_reg;
  psk_pkg::psk_word_t freq_reg, freq_next, phase_reg, lim_lo, lim_hi;
  logic band_change, msb_prev_reg, msb_rise, up, down;

  assign band_change = band_lvl != band_reg;
  assign lim_lo = psk_pkg::band_min(band_reg);
  assign lim_hi = psk_pkg::band_max(band_reg);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      band_reg <= psk_pkg::PSK_LVL_MID;
    end else begin
      band_reg <= band_lvl;
    end
  end

  always_comb begin
    freq_next = freq_reg;
    if (band_change) begin
      freq_next = psk_pkg::psk_word_t'(
        (psk_pkg::band_min(band_lvl) + psk_pkg::band_max(band_lvl)) / 2);
    end else if (up) begin
      freq_next = (lim_hi - freq_reg > STEP_W) ? psk_pkg::psk_word_t'(freq_reg + STEP_W)
                                                : lim_hi;
    end else if (down) begin
      freq_next = (freq_reg - lim_lo > STEP_W) ? psk_pkg::psk_word_t'(freq_reg - STEP_W)
                                                : lim_lo;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      freq_reg <= FREQ_RST;
    end else begin
      freq_reg <= freq_next;
    end
  end

  assign msb_rise = phase_reg[PW-1] & ~msb_prev_reg;

  // phase kick damps the loop; rate steps alone would only circle the lock point
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= '0;
      msb_prev_reg <= 1'b0;
    end else begin
      msb_prev_reg <= phase_reg[PW-1];
      if (up) begin
        phase_reg <= phase_reg + freq_reg + NUDGE_W;
      end else if (down) begin
        phase_reg <= phase_reg + freq_reg - NUDGE_W;
      end else begin
        phase_reg <= phase_reg + freq_reg;
      end
    end
  end

  // ****************************************
  // phase detector and lock
  // ****************************************
  psk_pkg::psk_pfd_t pfd_reg, pfd_next;
  logic [7:0] err_reg;
  logic hit, miss;
  logic [15:0] hits_reg;
  logic locked_reg;

  // loop is idle in bypass so the rate does not drift on stray edges
  always_comb begin
    pfd_next = pfd_reg;
    up = 1'b0;
    down = 1'b0;
    hit = 1'b0;
    miss = 1'b0;
    if (!bypass_on) begin
      unique case (pfd_reg)
        psk_pkg::PSK_PFD_IDLE: begin
          if (ref_rise && ret_rise) hit = 1'b1;
          else if (ref_rise) pfd_next = psk_pkg::PSK_PFD_REF_LEAD;
          else if (ret_rise) pfd_next = psk_pkg::PSK_PFD_RET_LEAD;
        end
        psk_pkg::PSK_PFD_REF_LEAD: begin
          if (ret_rise) begin
            up = 1'b1;
            hit = (err_reg <= 8'(LOCK_WIN));
            miss = !hit;
            pfd_next = ref_rise ? psk_pkg::PSK_PFD_REF_LEAD : psk_pkg::PSK_PFD_IDLE;
          end else if (ref_rise) begin
            up = 1'b1;
            miss = 1'b1;
          end
        end
        default: begin
          if (ref_rise) begin
            down = 1'b1;
            hit = (err_reg <= 8'(LOCK_WIN));
            miss = !hit;
            pfd_next = ret_rise ? psk_pkg::PSK_PFD_RET_LEAD : psk_pkg::PSK_PFD_IDLE;
          end else if (ret_rise) begin
            down = 1'b1;
            miss = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pfd_reg <= psk_pkg::PSK_PFD_IDLE;
      err_reg <= '0;
    end else begin
      pfd_reg <= pfd_next;
      if (pfd_next != pfd_reg || pfd_next == psk_pkg::PSK_PFD_IDLE) err_reg <= '0;
      else if (err_reg != 8'hFF) err_reg <= err_reg + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hits_reg <= '0;
      locked_reg <= 1'b0;
    end else if (band_change || sel_change || miss || bypass_on) begin
      hits_reg <= '0;
      locked_reg <= 1'b0;
    end else if (hit && !locked_reg) begin
      hits_reg <= hits_reg + 16'h0001;
      locked_reg <= (hits_reg == 16'(LOCK_HITS - 1));
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  psk_pkg::psk_func_t [3:0] func;
  logic [1:0] div_reg, div_next;
  logic div_tick;
  logic [3:0] out_next, out_reg;
  logic valid_reg;

  // bypass counts reference edges so division looks the same as in loop mode
  // ticks on the undivided rising edge, so divided edges line up with it
  assign div_tick = bypass_on ? ref_rise : msb_rise;
  assign div_next = div_tick ? div_reg + 2'h1 : div_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  always_comb begin
    logic base;
    base = 1'b0;
    for (int p = 0; p < 4; p++) begin
      func[p] = psk_pkg::pair_func(p, psk_pkg::decode_level(hi_f[p]),
                                   psk_pkg::decode_level(lo_f[p]));
      base = bypass_on ? ref_f
           : psk_pkg::skew_level(phase_reg, psk_pkg::unit_word(band_reg),
                                 func[p].steps);
      unique case (func[p].fn)
        psk_pkg::PSK_FN_DIV2: out_next[p] = div_next[0];
        psk_pkg::PSK_FN_DIV4: out_next[p] = div_next[1];
        psk_pkg::PSK_FN_INV: out_next[p] = ~base;
        default: out_next[p] = base;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= (bypass_on || locked_reg) && !sel_change && !band_change;
    end
  end

  assign pair_output_a = out_reg;
  assign pair_output_b = out_reg;
  assign outputs_valid = valid_reg;

  // ****************************************
  // checks
  // ****************************************
  a_band_window: assert property (@(posedge clock) disable iff (!arst_n)
    freq_reg >= lim_lo && freq_reg <= lim_hi) else $error("oscillator rate outside band");
  a_unit_size: assert property (@(posedge clock) disable iff (!arst_n)
    longint'(psk_pkg::unit_word(band_reg)) * psk_pkg::unit_factor(band_reg)
      > (longint'(1) << PW) - psk_pkg::unit_factor(band_reg))
    else $error("time unit does not match band factor");
  a_freq_up: assert property (@(posedge clock) disable iff (!arst_n)
    up && !band_change |=> freq_reg > $past(freq_reg) || freq_reg == lim_hi)
    else $error("late return did not speed oscillator");
  a_freq_down: assert property (@(posedge clock) disable iff (!arst_n)
    down && !band_change |=> freq_reg < $past(freq_reg) || freq_reg == lim_lo)
    else $error("early return did not slow oscillator");
  a_zero_offset: assert property (@(posedge clock) disable iff (!arst_n)
    !bypass_on && func[1].fn == psk_pkg::PSK_FN_SKEW && func[1].steps == 4'sh0
      && func[0].steps == 4'sh0 |=> pair_output_a[1] == pair_output_a[0])
    else $error("zero offset pairs disagree");
  a_div2_hold: assert property (@(posedge clock) disable iff (!arst_n)
    (!bypass_on && func[2].fn == psk_pkg::PSK_FN_DIV2)
      ##1 (!bypass_on && func[2].fn == psk_pkg::PSK_FN_DIV2 && !div_tick)
      |=> $stable(pair_output_a[2]))
    else $error("halved output moved without divider tick");
  a_invert_four: assert property (@(posedge clock) disable iff (!arst_n)
    !bypass_on && func[3].fn == psk_pkg::PSK_FN_INV |=> pair_output_a[3] != $past(phase_reg[PW-1]))
    else $error("pair four not inverted");
  a_bypass_ref: assert property (@(posedge clock) disable iff (!arst_n)
    bypass_on |=> pair_output_a[0] == $past(ref_f)) else $error("bypass output not following reference");
  a_relock_sel: assert property (@(posedge clock) disable iff (!arst_n)
    sel_change |=> !locked_reg && !outputs_valid) else $error("select change kept outputs valid");
  a_relock_band: assert property (@(posedge clock) disable iff (!arst_n)
    band_change && !bypass_on |=> !locked_reg ##1 !outputs_valid)
    else $error("band change kept lock");
  c_lock_gained: cover property (@(posedge clock) disable iff (!arst_n) $rose(locked_reg));
  c_bypass_run: cover property (@(posedge clock) disable iff (!arst_n) bypass_on ##1 ref_rise);
  c_band_switch: cover property (@(posedge clock) disable iff (!arst_n) band_change);
  c_quarter_rate: cover property (@(posedge clock) disable iff (!arst_n)
    func[2].fn == psk_pkg::PSK_FN_DIV4 && div_tick);

endmodule // psk_fanout

/* shared/psk_map.svh */
`ifndef PSK_MAP_SVH
`define PSK_MAP_SVH

// ****************************************
// clock and model scaling
// ****************************************
`define PSK_CLK_PERIOD_NS 25
`define PSK_CLK_KHZ (1000000 / `PSK_CLK_PERIOD_NS)
// oscillator model runs this many times slower than the real band
`define PSK_RATE_DIV 16
`define PSK_PHASE_W 24

// ****************************************
// bands, in MHz, and time unit factors
// ****************************************
`define PSK_BAND_LOW_MIN_MHZ 15
`define PSK_BAND_LOW_MAX_MHZ 30
`define PSK_BAND_MID_MIN_MHZ 25
`define PSK_BAND_MID_MAX_MHZ 50
`define PSK_BAND_HIGH_MIN_MHZ 40
`define PSK_BAND_HIGH_MAX_MHZ 100
`define PSK_N_LOW 44
`define PSK_N_MID 26
`define PSK_N_HIGH 16

// ****************************************
// loop and input conditioning
// ****************************************
`define PSK_SYNC_STAGES 3
`define PSK_FREQ_STEP 1024
`define PSK_LOCK_WIN 2
`define PSK_LOCK_HITS 64
// phase kick per detector decision, in phase word units
`define PSK_PHASE_NUDGE 262144

`endif

/* shared/psk_pkg.sv */
`include "psk_map.svh"

package psk_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PSK_LVL_LOW = 2'h0,
    PSK_LVL_MID = 2'h1,
    PSK_LVL_HIGH = 2'h3
  } psk_level_t;

  // three-level pin as seen by its two window comparators
  typedef struct packed {
    logic above_high;
    logic below_low;
  } psk_pin_t;

  typedef enum logic [1:0] {
    PSK_FN_SKEW = 2'h0,
    PSK_FN_DIV2 = 2'h1,
    PSK_FN_DIV4 = 2'h3,
    PSK_FN_INV = 2'h2
  } psk_fn_t;

  typedef struct packed {
    psk_fn_t fn;
    logic signed [3:0] steps;
  } psk_func_t;

  typedef enum logic [1:0] {
    PSK_PFD_IDLE = 2'h0,
    PSK_PFD_REF_LEAD = 2'h1,
    PSK_PFD_RET_LEAD = 2'h2
  } psk_pfd_t;

  typedef logic [`PSK_PHASE_W-1:0] psk_word_t;

  // ****************************************
  // functions
  // ****************************************
  function automatic psk_level_t decode_level(psk_pin_t p);
    if (p.above_high) return PSK_LVL_HIGH;
    if (p.below_low) return PSK_LVL_LOW;
    return PSK_LVL_MID;
  endfunction

  function automatic int digit(psk_level_t l);
    return (l == PSK_LVL_LOW) ? 0 : (l == PSK_LVL_MID) ? 1 : 2;
  endfunction

  function automatic psk_word_t mhz_word(int mhz);
    longint w;
    w = (longint'(mhz) * 1000 * (longint'(1) << `PSK_PHASE_W))
        / (longint'(`PSK_CLK_KHZ) * `PSK_RATE_DIV);
    return psk_word_t'(w);
  endfunction

  function automatic psk_word_t band_min(psk_level_t b);
    unique case (b)
      PSK_LVL_LOW: return mhz_word(`PSK_BAND_LOW_MIN_MHZ);
      PSK_LVL_MID: return mhz_word(`PSK_BAND_MID_MIN_MHZ);
      default: return mhz_word(`PSK_BAND_HIGH_MIN_MHZ);
    endcase
  endfunction

  function automatic psk_word_t band_max(psk_level_t b);
    unique case (b)
      PSK_LVL_LOW: return mhz_word(`PSK_BAND_LOW_MAX_MHZ);
      PSK_LVL_MID: return mhz_word(`PSK_BAND_MID_MAX_MHZ);
      default: return mhz_word(`PSK_BAND_HIGH_MAX_MHZ);
    endcase
  endfunction

  function automatic int unit_factor(psk_level_t b);
    unique case (b)
      PSK_LVL_LOW: return `PSK_N_LOW;
      PSK_LVL_MID: return `PSK_N_MID;
      default: return `PSK_N_HIGH;
    endcase
  endfunction

  // one oscillator cycle is the full phase circle, so a time unit is circle / N
  function automatic psk_word_t unit_word(psk_level_t b);
    return psk_word_t'((longint'(1) << `PSK_PHASE_W) / unit_factor(b));
  endfunction

  function automatic psk_func_t pair_func(int pair, psk_level_t hi, psk_level_t lo);
    psk_func_t f;
    int idx;
    idx = 3 * digit(hi) + digit(lo);
    f.fn = PSK_FN_SKEW;
    f.steps = 4'(idx - 4);
    if (pair >= 2) begin
      f.steps = 4'(2 * (idx - 4));
      if (idx == 0) begin
        f.fn = PSK_FN_DIV2;
        f.steps = 4'h0;
      end else if (idx == 8) begin
        f.fn = (pair == 2) ? PSK_FN_DIV4 : PSK_FN_INV;
        f.steps = 4'h0;
      end
    end
    return f;
  endfunction

  // later output = earlier phase point
  function automatic logic skew_level(psk_word_t ph, psk_word_t unit, logic signed [3:0] k);
    psk_word_t mag;
    psk_word_t p;
    mag = psk_word_t'(k < 0 ? -k : k);
    p = (k < 0) ? psk_word_t'(ph + mag * unit) : psk_word_t'(ph - mag * unit);
    return p[`PSK_PHASE_W-1];
  endfunction

endpackage

/* testbench/psk_ref_source.sv */
// ****************************************
// board reference clock source
// ****************************************
module psk_ref_source (
  input wire logic clock,
  input wire logic run,
  input wire logic [7:0] half_cycles,
  output logic ref_clock_input
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] count_reg;

  // stands still low between bursts, as a gated board source would
  initial ref_clock_input = 1'b0;
  initial count_reg = 8'h00;
  // in loop mode the bench picks a rate inside the strapped band; the bypass rate lies above it
  // a returned undivided output means the oscillator runs at this rate
  always @(negedge clock) begin
    if (!run) begin
      ref_clock_input <= 1'b0;
      count_reg <= 8'h00;
    end else if (count_reg + 8'h01 >= half_cycles) begin
      ref_clock_input <= ~ref_clock_input;
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_reg + 8'h01;
    end
  end
endmodule // psk_ref_source

/* testbench/psk_fanout_tb.sv */
module psk_fanout_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // pins and instances
  // ****************************************
  localparam logic [1:0] P_LOW = 2'h1;
  localparam logic [1:0] P_MID = 2'h0;
  localparam logic [1:0] P_HIGH = 2'h2;
  localparam logic [1:0] P_BOTH = 2'h3;

  logic clock;
  logic arst_n;
  logic ref_run;
  logic [7:0] ref_half;
  logic ref_clk;
  psk_pkg::psk_pin_t band;
  psk_pkg::psk_pin_t bypass;
  psk_pkg::psk_pin_t [3:0] sel_lo;
  psk_pkg::psk_pin_t [3:0] sel_hi;
  logic [3:0] qa;
  logic [3:0] qb;
  logic valid;
  int err_count = 0;
  int cmp_count = 0;

  psk_ref_source src (
    .clock(clock),
    .run(ref_run),
    .half_cycles(ref_half),
    .ref_clock_input(ref_clk)
  );

  // pair 1 output a is wired back as the loop return, zero offset
  psk_fanout #(.LOCK_HITS(4)) dut (
    .clock(clock),
    .arst_n(arst_n),
    .ref_clock_input(ref_clk),
    .loop_return_input(qa[0]),
    .band_select(band),
    .bypass_select(bypass),
    .pair_select_low_digit(sel_lo),
    .pair_select_high_digit(sel_hi),
    .pair_output_a(qa),
    .pair_output_b(qb),
    .outputs_valid(valid)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************************************
  // compare and drive helpers
  // ****************************************
  task automatic close_out;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_bit(string what, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_range(string what, int lo, int hi, int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic set_pair(int p, logic [1:0] hi, logic [1:0] lo);
    @(negedge clock);
    sel_hi[p] = hi;
    sel_lo[p] = lo;
  endtask

  // bounded wait on the valid flag reaching a level
  task automatic wait_valid(logic lvl, int limit, output int n);
    n = 0;
    while (valid !== lvl && n < limit) begin
      @(negedge clock);
      n++;
    end
  endtask

  // counts rises of the reference and of each pair, plus pair 1 high time
  task automatic measure(int cycles, output int r[5], output int hi1, output int same41);
    logic [4:0] prev;
    logic [4:0] now;
    hi1 = 0;
    same41 = 0;
    r = '{0, 0, 0, 0, 0};
    @(negedge clock);
    prev = {qa, ref_clk};
    repeat (cycles) begin
      @(negedge clock);
      now = {qa, ref_clk};
      cmp_bit("pair copy equal", 1'b1, qa === qb);
      for (int i = 0; i < 5; i++) if (now[i] && !prev[i]) r[i]++;
      if (qa[0]) hi1++;
      if (qa[3] === qa[0]) same41++;
      prev = now;
    end
  endtask

  // cycles from a rise on pair a to the next rise on pair b
  task automatic lag(int a, int b, output int n);
    logic pb;
    n = 0;
    pb = 1'b0;
    while (!(qa[a] === 1'b1)) @(negedge clock);
    while (qa[a] === 1'b1) @(negedge clock);
    // pb keeps pair b as it stood just before pair a rose, so a shared edge counts as zero
    while (!(qa[a] === 1'b1)) begin
      pb = qa[b];
      @(negedge clock);
    end
    while (!(qa[b] === 1'b1 && pb === 1'b0) && n < 40) begin
      pb = qa[b];
      @(negedge clock);
      n++;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    cmp_bit("valid in reset", 1'b0, valid);
    cmp_bit("pair1 in reset", 1'b0, qa[0]);
  endtask

  task automatic t_bypass;
    int r[5];
    int hi1;
    int same;
    int n;
    @(negedge clock);
    bypass = P_HIGH;
    ref_half = 8'h04;
    ref_run = 1'b1;
    set_pair(0, P_MID, P_MID);
    set_pair(2, P_LOW, P_LOW);
    set_pair(3, P_BOTH, P_HIGH);
    wait_valid(1'b1, 60, n);
    cmp_bit("bypass valid", 1'b1, valid);
    measure(512, r, hi1, same);
    cmp_range("ref rises", 63, 65, r[0]);
    cmp_range("bypass pair1 rises", r[0] - 1, r[0] + 1, r[1]);
    cmp_range("bypass pair3 half", r[0] / 2 - 1, r[0] / 2 + 1, r[3]);
    cmp_range("bypass pair4 rises", r[0] - 1, r[0] + 1, r[4]);
    cmp_range("bypass pair4 inverted", 0, 8, same);
    cmp_range("bypass pair1 duty", 240, 272, hi1);
    set_pair(2, P_HIGH, P_HIGH);
    wait_valid(1'b0, 8, n);
    cmp_bit("valid drop on select", 1'b0, valid);
    @(negedge clock);
    bypass = P_MID;
    wait_valid(1'b1, 60, n);
    cmp_bit("bypass open valid", 1'b1, valid);
    measure(512, r, hi1, same);
    cmp_range("bypass pair3 quarter", r[0] / 4 - 1, r[0] / 4 + 1, r[3]);
  endtask

  task automatic t_loop;
    int r[5];
    int hi1;
    int same;
    int n;
    @(negedge clock);
    bypass = P_LOW;
    ref_half = 8'h09;
    set_pair(1, P_HIGH, P_HIGH);
    set_pair(2, P_MID, P_MID);
    set_pair(3, P_LOW, P_HIGH);
    wait_valid(1'b1, 8000, n);
    cmp_bit("loop locked", 1'b1, valid);
    measure(720, r, hi1, same);
    cmp_range("loop pair1 rises", r[0] - 1, r[0] + 1, r[1]);
    cmp_range("loop pair2 rises", r[0] - 1, r[0] + 1, r[2]);
    cmp_range("loop pair1 duty", 320, 400, hi1);
    lag(0, 1, n);
    cmp_range("pair2 late four units", 1, 4, n);
    lag(3, 0, n);
    cmp_range("pair4 early four units", 1, 4, n);
    lag(0, 2, n);
    cmp_range("pair3 zero offset", 0, 0, n);
    @(negedge clock);
    band = P_LOW;
    wait_valid(1'b0, 8, n);
    cmp_bit("valid drop on band", 1'b0, valid);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    arst_n = 1'b0;
    ref_run = 1'b0;
    ref_half = 8'h04;
    band = P_MID;
    bypass = P_LOW;
    sel_lo = {P_MID, P_MID, P_MID, P_MID};
    sel_hi = {P_MID, P_MID, P_MID, P_MID};
    repeat (4) @(negedge clock);
    t_reset();
    arst_n = 1'b1;
    t_bypass();
    t_loop();
    close_out();
  end

  // all scenarios together stay well under half this span
  initial begin
    #(40000 * 25);
    err_count++;
    close_out();
  end
endmodule // psk_fanout_tb
